// file: logic/mdio_frame_engine.sv
// Management frame engine: serial frames in, register requests out.
`timescale 1ns/10ps
module mdio_frame_engine (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst_b,
  // Management pins, sampled on mclk
  input  wire logic                          mdc,
  input  wire logic                          mdio_in,
  output logic                               mdio_out,
  output logic                               mdio_oe_b,
  // Station address of this device
  input  wire logic [4:0]                    phy_address,
  // Register side
  output sgmii_mgmt_pkg::mgmt_req_t          req,
  input  wire logic [sgmii_mgmt_pkg::DATA_W-1:0] rdata
);

  typedef enum {IDLE, HEADER, TURN_ONE, TURN_TWO, DATA} frame_st_t;

  frame_st_t                              state;
  logic                                   mdc_prev;
  logic                                   bit_prev;
  logic [sgmii_mgmt_pkg::HDR_BITS-1:0]    hdr;
  logic [sgmii_mgmt_pkg::DATA_W-1:0]      sh;
  logic [sgmii_mgmt_pkg::CNT_W-1:0]       cnt;
  logic                                   is_read;
  logic                                   hit;
  logic                                   edge_up;
  logic [sgmii_mgmt_pkg::HDR_BITS-1:0]    next_hdr;
  logic [1:0]                             next_op;
  logic                                   next_hit;

  assign edge_up  = mdc & ~mdc_prev;
  assign next_hdr = {hdr[sgmii_mgmt_pkg::HDR_BITS-2:0], mdio_in};
  assign next_op  = next_hdr[sgmii_mgmt_pkg::HDR_OP_HI:
                             sgmii_mgmt_pkg::HDR_OP_LO];
  assign next_hit = next_hdr[sgmii_mgmt_pkg::HDR_ST] &&
    next_hdr[sgmii_mgmt_pkg::HDR_PHY_HI:sgmii_mgmt_pkg::HDR_PHY_LO]
      == phy_address;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mdc_prev <= 1'b0;
    end else begin
      mdc_prev <= mdc;
    end
  end

  // ==========================================================================
  // Frame sequencing
  // A frame opens on the first 0 after a 1, so a shortened preamble works.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state     <= IDLE;
      bit_prev  <= 1'b0;
      hdr       <= '0;
      sh        <= '0;
      cnt       <= '0;
      is_read   <= 1'b0;
      hit       <= 1'b0;
      req       <= '0;
      mdio_out  <= 1'b0;
      mdio_oe_b <= 1'b1;
    end else begin
      req.valid <= 1'b0;
      if (edge_up) begin
        bit_prev <= mdio_in;
        case (state)
          IDLE: begin
            cnt <= '0;
            if (bit_prev && !mdio_in) begin
              state <= HEADER;
            end
          end
          HEADER: begin
            hdr <= next_hdr;
            cnt <= cnt + 1'b1;
            if (cnt == sgmii_mgmt_pkg::HDR_LAST) begin
              is_read <= next_op == sgmii_mgmt_pkg::OP_READ;
              hit     <= next_hit && (next_op == sgmii_mgmt_pkg::OP_READ ||
                                      next_op == sgmii_mgmt_pkg::OP_WRITE);
              state   <= TURN_ONE;
              // The read is asked for now so data is ready two edges on.
              req.valid <= next_hit && next_op == sgmii_mgmt_pkg::OP_READ;
              req.write <= 1'b0;
              req.addr  <= next_hdr[sgmii_mgmt_pkg::ADDR_W-1:0];
            end
          end
          TURN_ONE: begin
            state <= TURN_TWO;
            if (is_read && hit) begin
              mdio_out  <= 1'b0;
              mdio_oe_b <= 1'b0;
            end
          end
          TURN_TWO: begin
            cnt   <= '0;
            state <= DATA;
            if (is_read && hit) begin
              mdio_out <= rdata[sgmii_mgmt_pkg::DATA_W-1];
              sh       <= {rdata[sgmii_mgmt_pkg::DATA_W-2:0], 1'b0};
            end
          end
          DATA: begin
            cnt <= cnt + 1'b1;
            if (is_read) begin
              mdio_out <= sh[sgmii_mgmt_pkg::DATA_W-1];
              sh       <= {sh[sgmii_mgmt_pkg::DATA_W-2:0], 1'b0};
            end else begin
              sh <= {sh[sgmii_mgmt_pkg::DATA_W-2:0], mdio_in};
            end
            if (cnt == sgmii_mgmt_pkg::DATA_LAST) begin
              state     <= IDLE;
              mdio_oe_b <= 1'b1;
              mdio_out  <= 1'b0;
              req.valid <= hit && !is_read;
              req.write <= 1'b1;
              req.wdata <= {sh[sgmii_mgmt_pkg::DATA_W-2:0], mdio_in};
            end
          end
          default: state <= IDLE;
        endcase
      end
    end
  end

endmodule

// file: logic/sgmii_mgmt_control_regs.sv
// Management register set of the serial-link sublayer, reached over MDIO.
`timescale 1ns/10ps
module sgmii_mgmt_control_regs #(
  parameter bit          TBI_VARIANT = 1'b0,
  // Identifier words; the values are arbitrary.
  parameter logic [15:0] ID_HIGH     = 16'h0000,
  parameter logic [15:0] ID_LOW      = 16'h0000
) (
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst_b,
  // Management pins
  input  wire logic                         mdc,
  input  wire logic                         mdio_in,
  output logic                              mdio_out,
  output logic                              mdio_oe_b,
  input  wire logic [4:0]                   phy_address,
  // State from the sublayer and negotiation logic
  input  wire sgmii_mgmt_pkg::link_status_t link_status,
  input  wire logic [15:0]                  adv_word,
  input  wire logic [15:0]                  partner_word,
  input  wire logic [15:0]                  expansion_word,
  input  wire logic [15:0]                  np_rx_word,
  // Controls to the sublayer
  output sgmii_mgmt_pkg::link_ctrl_t        link_ctrl,
  output logic [15:0]                       np_tx_word,
  output logic [15:0]                       an_irq_control
);

  sgmii_mgmt_pkg::mgmt_req_t req;
  logic [15:0]               rdata;
  logic                      soft_reset;
  logic                      loopback;
  logic                      an_enable;
  logic                      power_down;
  logic                      isolate;
  logic                      restart_an;
  logic                      unidir;
  logic                      link_latch;
  logic                      fault_latch;
  logic [15:0]               ctrl_word;
  logic [15:0]               status_word;
  logic [15:0]               next_rdata;
  logic                      rd_req;
  logic                      wr_ctrl;

  mdio_frame_engine engine (
    .mclk        (mclk),
    .rst_b       (rst_b),
    .mdc         (mdc),
    .mdio_in     (mdio_in),
    .mdio_out    (mdio_out),
    .mdio_oe_b   (mdio_oe_b),
    .phy_address (phy_address),
    .req         (req),
    .rdata       (rdata)
  );

  assign rd_req  = req.valid && !req.write;
  assign wr_ctrl = req.valid && req.write &&
                   req.addr == sgmii_mgmt_pkg::A_CTRL;

  // ==========================================================================
  // Control register
  // A core reset returns every field except the reset bit itself to its reset value;
  // it and rst_b are the only paths that lower power-down.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      soft_reset <= 1'b0;
      loopback   <= 1'b0;
      an_enable  <= 1'b1;
      power_down <= 1'b0;
      isolate    <= 1'b1;
      restart_an <= 1'b0;
      unidir     <= 1'b0;
    end else if (wr_ctrl && req.wdata[sgmii_mgmt_pkg::C_RESET]) begin
      soft_reset <= 1'b1;
      loopback   <= 1'b0;
      an_enable  <= 1'b1;
      power_down <= 1'b0;
      isolate    <= 1'b1;
      restart_an <= 1'b0;
      unidir     <= 1'b0;
    end else if (wr_ctrl) begin
      soft_reset <= 1'b0;
      loopback   <= req.wdata[sgmii_mgmt_pkg::C_LOOP];
      an_enable  <= req.wdata[sgmii_mgmt_pkg::C_ANEN];
      power_down <= power_down |
                    req.wdata[sgmii_mgmt_pkg::C_PDOWN];
      isolate    <= req.wdata[sgmii_mgmt_pkg::C_ISO];
      restart_an <= req.wdata[sgmii_mgmt_pkg::C_RSTAN];
      unidir     <= req.wdata[sgmii_mgmt_pkg::C_UNI];
    end else begin
      soft_reset <= 1'b0;
      restart_an <= 1'b0;
    end
  end

  // ==========================================================================
  // Outputs to the sublayer, one cycle behind the register fields
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      link_ctrl <= '0;
      link_ctrl.an_enable <= 1'b1;
      link_ctrl.isolate   <= 1'b1;
    end else begin
      link_ctrl.core_reset        <= soft_reset;
      link_ctrl.an_restart        <= restart_an;
      link_ctrl.internal_loopback <= loopback && !TBI_VARIANT;
      link_ctrl.ewrap             <= loopback && TBI_VARIANT;
      link_ctrl.power_down        <= power_down && !TBI_VARIANT;
      link_ctrl.isolate           <= isolate;
      link_ctrl.an_enable         <= an_enable;
      link_ctrl.unidirectional    <= unidir;
    end
  end

  // ==========================================================================
  // Plain read/write words
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      np_tx_word     <= sgmii_mgmt_pkg::NP_TX_RESET;
      an_irq_control <= sgmii_mgmt_pkg::IRQ_RESET;
    end else if (req.valid && req.write) begin
      if (req.addr == sgmii_mgmt_pkg::A_NP_TX) begin
        np_tx_word <= req.wdata;
      end
      if (req.addr == sgmii_mgmt_pkg::A_IRQ) begin
        an_irq_control <= req.wdata;
      end
    end
  end

  // ==========================================================================
  // Latched link and fault status, refreshed by a read of the status word
  // A drop or a fault in the read cycle itself is kept, since the refresh
  // takes the live value rather than a constant.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      link_latch  <= 1'b0;
      fault_latch <= 1'b0;
    end else if (rd_req && req.addr == sgmii_mgmt_pkg::A_STATUS) begin
      link_latch  <= link_status.serial_link_up;
      fault_latch <= link_status.remote_fault;
    end else begin
      link_latch  <= link_latch & link_status.serial_link_up;
      fault_latch <= fault_latch | link_status.remote_fault;
    end
  end

  // ==========================================================================
  // Read decode
  always_comb begin
    ctrl_word = sgmii_mgmt_pkg::CTRL_FIXED;
    ctrl_word[sgmii_mgmt_pkg::C_RESET] = soft_reset;
    ctrl_word[sgmii_mgmt_pkg::C_LOOP]  = loopback;
    ctrl_word[sgmii_mgmt_pkg::C_ANEN]  = an_enable;
    ctrl_word[sgmii_mgmt_pkg::C_PDOWN] = power_down;
    ctrl_word[sgmii_mgmt_pkg::C_ISO]   = isolate;
    ctrl_word[sgmii_mgmt_pkg::C_RSTAN] = restart_an;
    ctrl_word[sgmii_mgmt_pkg::C_UNI]   = unidir;
    status_word = sgmii_mgmt_pkg::STATUS_FIXED;
    status_word[sgmii_mgmt_pkg::S_ANDONE] = link_status.an_complete;
    status_word[sgmii_mgmt_pkg::S_RFAULT] = fault_latch;
    status_word[sgmii_mgmt_pkg::S_LINK]   = link_latch;
    case (req.addr)
      sgmii_mgmt_pkg::A_CTRL:   next_rdata = ctrl_word;
      sgmii_mgmt_pkg::A_STATUS: next_rdata = status_word;
      sgmii_mgmt_pkg::A_ID_HI:  next_rdata = ID_HIGH;
      sgmii_mgmt_pkg::A_ID_LO:  next_rdata = ID_LOW;
      sgmii_mgmt_pkg::A_ADV:    next_rdata = adv_word;
      sgmii_mgmt_pkg::A_LP:     next_rdata = partner_word;
      sgmii_mgmt_pkg::A_EXP:    next_rdata = expansion_word;
      sgmii_mgmt_pkg::A_NP_TX:  next_rdata = np_tx_word;
      sgmii_mgmt_pkg::A_NP_RX:  next_rdata = np_rx_word;
      sgmii_mgmt_pkg::A_EXT:    next_rdata = sgmii_mgmt_pkg::EXT_STATUS;
      sgmii_mgmt_pkg::A_IRQ:    next_rdata = an_irq_control;
      default:                  next_rdata = '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdata <= '0;
    end else if (rd_req) begin
      rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  logic rd_ctrl;
  logic wr_hole;
  assign rd_ctrl = rd_req && req.addr == sgmii_mgmt_pkg::A_CTRL;
  assign wr_hole = req.valid && req.write &&
                   req.addr > sgmii_mgmt_pkg::A_NP_RX &&
                   req.addr != sgmii_mgmt_pkg::A_EXT &&
                   req.addr != sgmii_mgmt_pkg::A_IRQ;

  speed_bits_a: assert property (rd_ctrl |=> !rdata[13] && rdata[6])
    else $error("speed bits wrong");
  duplex_bit_a: assert property (rd_ctrl |=> rdata[8])
    else $error("duplex bit not 1");
  col_test_a: assert property (rd_ctrl |=> !rdata[7])
    else $error("collision test bit not 0");
  reserved_bits_a: assert property (rd_ctrl |=> rdata[4:0] == 5'h00)
    else $error("reserved bits not 0");
  unmapped_read_a: assert property (
    rd_req && req.addr inside {[5'h09:5'h0E], [5'h11:5'h1F]} |=> rdata == '0)
    else $error("unmapped read not zero");
  unmapped_write_a: assert property (
    wr_hole |=> $stable(np_tx_word) && $stable(an_irq_control) &&
                $stable(isolate) && $stable(an_enable))
    else $error("unmapped write had effect");
  ext_decode_a: assert property (
    rd_req && req.addr == sgmii_mgmt_pkg::A_EXT |=> rdata == 16'h8000)
    else $error("extended status decode wrong");
  restart_clear_a: assert property (
    wr_ctrl && req.wdata[9] && !req.wdata[15]
      |=> restart_an ##1 !restart_an && link_ctrl.an_restart ##1
          !link_ctrl.an_restart)
    else $error("restart bit not self-clearing");
  core_reset_a: assert property (
    wr_ctrl && req.wdata[15] |=> soft_reset && an_enable && isolate &&
      !power_down ##1 !soft_reset && link_ctrl.core_reset)
    else $error("core reset not fired");
  pdown_sticky_a: assert property (
    power_down && !(wr_ctrl && req.wdata[15]) |=> power_down)
    else $error("power-down cleared without reset");
  pdown_tbi_a: assert property (
    TBI_VARIANT |-> !link_ctrl.power_down)
    else $error("power-down active in ten-bit variant");
  loop_route_a: assert property (
    ##1 link_ctrl.internal_loopback == ($past(loopback) && !TBI_VARIANT) &&
        link_ctrl.ewrap == ($past(loopback) && TBI_VARIANT))
    else $error("loopback routed wrongly");
  unidir_write_a: assert property (
    wr_ctrl && !req.wdata[15] |=> unidir == $past(req.wdata[5]) ##1
      link_ctrl.unidirectional == $past(unidir))
    else $error("unidirectional bit not stored");
  link_latch_a: assert property (
    !link_status.serial_link_up |=> !link_latch)
    else $error("link drop not latched");
  fault_latch_a: assert property (
    link_status.remote_fault |=> fault_latch)
    else $error("medium fault not latched");
  status_fixed_a: assert property (
    rd_req && req.addr == sgmii_mgmt_pkg::A_STATUS
      |=> (rdata & 16'hFFCB) == sgmii_mgmt_pkg::STATUS_FIXED)
    else $error("status constant bits wrong");
  partner_read_a: assert property (
    rd_req && req.addr == sgmii_mgmt_pkg::A_LP
      |=> rdata == $past(partner_word))
    else $error("partner word decode wrong");
  id_read_a: assert property (
    rd_req && req.addr == sgmii_mgmt_pkg::A_ID_LO |=> rdata == ID_LOW)
    else $error("identifier decode wrong");
  np_tx_write_a: assert property (
    req.valid && req.write && req.addr == sgmii_mgmt_pkg::A_NP_TX
      |=> np_tx_word == $past(req.wdata))
    else $error("next-page word not written");
  irq_write_a: assert property (
    req.valid && req.write && req.addr == sgmii_mgmt_pkg::A_IRQ
      |=> an_irq_control == $past(req.wdata))
    else $error("interrupt control word not written");
  ro_write_a: assert property (
    req.valid && req.write && req.addr == sgmii_mgmt_pkg::A_ADV
      |=> $stable(np_tx_word) && $stable(an_irq_control) && $stable(unidir))
    else $error("read-only word took a write");
  pdown_set_a: assert property (
    wr_ctrl && req.wdata[11] && !req.wdata[15] |=> power_down)
    else $error("power-down not set");
  anen_write_a: assert property (
    wr_ctrl && !req.wdata[15] |=> an_enable == $past(req.wdata[12]))
    else $error("negotiation enable not stored");
  isolate_out_a: assert property (
    ##1 link_ctrl.isolate == $past(isolate))
    else $error("isolate not passed on");

  ctrl_write_c: cover property (wr_ctrl ##[1:40] rd_ctrl);
  core_reset_c: cover property (link_ctrl.core_reset);
  status_read_c: cover property (
    rd_req && req.addr == sgmii_mgmt_pkg::A_STATUS);
  restart_c: cover property (link_ctrl.an_restart);
  pdown_reset_c: cover property (
    power_down && wr_ctrl ##1 soft_reset);

endmodule

// file: logic/sgmii_mgmt_pkg.sv
// Constants, field layouts and carrier types of the serial-link management set.
package sgmii_mgmt_pkg;

  // ==========================================================================
  // Widths and frame layout
  localparam int DATA_W     = 16;
  localparam int ADDR_W     = 5;
  localparam int HDR_BITS   = 13;
  localparam int CNT_W      = 4;
  localparam int HDR_ST     = 12;
  localparam int HDR_OP_HI  = 11;
  localparam int HDR_OP_LO  = 10;
  localparam int HDR_PHY_HI = 9;
  localparam int HDR_PHY_LO = 5;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [CNT_W-1:0] HDR_LAST  = 4'hC;
  localparam logic [CNT_W-1:0] DATA_LAST = 4'hF;

  // ==========================================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] A_CTRL   = 5'h00;
  localparam logic [ADDR_W-1:0] A_STATUS = 5'h01;
  localparam logic [ADDR_W-1:0] A_ID_HI  = 5'h02;
  localparam logic [ADDR_W-1:0] A_ID_LO  = 5'h03;
  localparam logic [ADDR_W-1:0] A_ADV    = 5'h04;
  localparam logic [ADDR_W-1:0] A_LP     = 5'h05;
  localparam logic [ADDR_W-1:0] A_EXP    = 5'h06;
  localparam logic [ADDR_W-1:0] A_NP_TX  = 5'h07;
  localparam logic [ADDR_W-1:0] A_NP_RX  = 5'h08;
  localparam logic [ADDR_W-1:0] A_EXT    = 5'h0F;
  localparam logic [ADDR_W-1:0] A_IRQ    = 5'h10;

  // ==========================================================================
  // Control register fields
  localparam int C_RESET = 15;
  localparam int C_LOOP  = 14;
  localparam int C_SPDL  = 13;
  localparam int C_ANEN  = 12;
  localparam int C_PDOWN = 11;
  localparam int C_ISO   = 10;
  localparam int C_RSTAN = 9;
  localparam int C_DUPLX = 8;
  localparam int C_COLT  = 7;
  localparam int C_SPDM  = 6;
  localparam int C_UNI   = 5;
  localparam logic [DATA_W-1:0] CTRL_FIXED = 16'h0140;

  // ==========================================================================
  // Status register fields and constant words
  localparam int S_ANDONE = 5;
  localparam int S_RFAULT = 4;
  localparam int S_LINK   = 2;
  localparam logic [DATA_W-1:0] STATUS_FIXED = 16'h01C8;
  localparam logic [DATA_W-1:0] EXT_STATUS   = 16'h8000;
  localparam logic [DATA_W-1:0] NP_TX_RESET  = 16'h0000;
  localparam logic [DATA_W-1:0] IRQ_RESET    = 16'h0000;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mgmt_req_t;

  typedef struct packed {
    logic serial_link_up;
    logic an_complete;
    logic remote_fault;
  } link_status_t;

  typedef struct packed {
    logic core_reset;
    logic an_restart;
    logic internal_loopback;
    logic ewrap;
    logic power_down;
    logic isolate;
    logic an_enable;
    logic unidirectional;
  } link_ctrl_t;

endpackage

// file: test/mdio_station.sv
// Management station model that clocks frames onto the pins.
`timescale 1ns/10ps
module mdio_station (
  // Clock
  input  wire logic mclk,
  // Device side of the data wire
  input  wire logic mdio_out,
  input  wire logic mdio_oe_b,
  // Pins driven by the station
  output logic      mdc,
  output logic      mdio_in
);
  logic bit_q = 1'b1;

  initial mdc = 1'b0;

  // The wire has a pull-up, so a line that nobody drives reads 1.
  assign mdio_in = !mdio_oe_b ? mdio_out : bit_q;

  // ======
  // Four preamble ones, then 32 frame bits, mdc low and high two mclk each.
  // Reads release the wire after the address and sample it just before
  // each rising mdc, while the device still holds its previous bit.
  task automatic xfer(input logic [31:0] f, input logic rd,
                      output logic [15:0] got);
    got = '0;
    @(posedge mclk);
    for (int i = -4; i < 32; i++) begin
      #1;
      mdc = 1'b0;
      bit_q = (i < 0 || (rd && i >= 14)) ? 1'b1 : f[31-i];
      repeat (2) @(posedge mclk);
      #1;
      if (i >= 16) got = {got[14:0], mdio_in};
      mdc = 1'b1;
      repeat (2) @(posedge mclk);
    end
    #1;
    mdc = 1'b0;
    bit_q = 1'b1;
  endtask
endmodule

// file: test/tb_top.sv
// Self-checking bench of the serial-link management register set.
`timescale 1ns/10ps
module tb_top;
  // ======
  // Clock, pins and design
  logic                         mclk = 1'b0;
  logic                         rst_b = 1'b0;
  logic                         mdc;
  logic                         mdio_in;
  logic                         mdio_out;
  logic                         mdio_oe_b;
  logic [4:0]                   phy = 5'h05;
  sgmii_mgmt_pkg::link_status_t st = '0;
  sgmii_mgmt_pkg::link_ctrl_t   ctl;
  sgmii_mgmt_pkg::link_ctrl_t   ctl_tbi;
  logic [15:0]                  np_tx;
  logic [15:0]                  irq_ctl;
  logic [15:0]                  got;
  int                           err_total = 0;
  int                           cmp_count = 0;
  int                           n_rst = 0;
  int                           n_an = 0;

  always #5 mclk = ~mclk;

  sgmii_mgmt_control_regs u_dut (
    .mclk(mclk), .rst_b(rst_b), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe_b(mdio_oe_b), .phy_address(phy),
    .link_status(st), .adv_word(16'hA001), .partner_word(16'hB002),
    .expansion_word(16'hC003), .np_rx_word(16'hD004),
    .link_ctrl(ctl), .np_tx_word(np_tx), .an_irq_control(irq_ctl));

  mdio_station u_sta (.mclk(mclk), .mdio_out(mdio_out),
    .mdio_oe_b(mdio_oe_b), .mdc(mdc), .mdio_in(mdio_in));

  // The ten-bit variant hears the same frames but never drives the wire.
  sgmii_mgmt_control_regs #(.TBI_VARIANT(1'b1)) u_dut_tbi (
    .mclk(mclk), .rst_b(rst_b), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(), .mdio_oe_b(), .phy_address(phy),
    .link_status(st), .adv_word(16'hA001), .partner_word(16'hB002),
    .expansion_word(16'hC003), .np_rx_word(16'hD004),
    .link_ctrl(ctl_tbi), .np_tx_word(), .an_irq_control());

  // Pulses last one cycle, so they are counted at the falling edge, away
  // from the rising edge that launches them.
  always @(negedge mclk) begin
    if (ctl.core_reset === 1'b1) n_rst++;
    if (ctl.an_restart === 1'b1) n_an++;
  end

  // ======
  // Shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [4:0] ph, input logic [4:0] a);
    u_sta.xfer({2'b01, sgmii_mgmt_pkg::OP_READ, ph, a, 18'h3FFFF},
               1'b1, got);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    u_sta.xfer({2'b01, sgmii_mgmt_pkg::OP_WRITE, phy, a, 2'b10, d},
               1'b0, got);
  endtask

  task automatic finish_test;
    $display("errors %0d, checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ======
  // Scenarios
  task automatic t_reset;
    rd(phy, 5'h00);
    chk(got, 16'h1540);
    chk({8'h00, ctl}, 16'h0006);
  endtask

  task automatic t_fields;
    wr(5'h00, 16'h74BF);
    rd(phy, 5'h00);
    chk(got, 16'h5560);
    chk({8'h00, ctl}, 16'h0027);
    chk({8'h00, ctl_tbi}, 16'h0017);
    wr(5'h00, 16'h0000);
    rd(phy, 5'h00);
    chk(got, 16'h0140);
    chk({8'h00, ctl}, 16'h0000);
  endtask

  task automatic t_restart;
    n_an = 0;
    wr(5'h00, 16'h1200);
    rd(phy, 5'h00);
    chk(got, 16'h1140);
    chk(16'(n_an), 16'h0001);
  endtask

  task automatic t_pdown;
    wr(5'h00, 16'h0800);
    wr(5'h00, 16'h0000);
    rd(phy, 5'h00);
    chk(got, 16'h0940);
    chk({8'h00, ctl}, 16'h0008);
    chk({8'h00, ctl_tbi}, 16'h0000);
    n_rst = 0;
    wr(5'h00, 16'h8000);
    rd(phy, 5'h00);
    chk(got, 16'h1540);
    chk(16'(n_rst), 16'h0001);
  endtask

  task automatic t_map;
    logic [4:0]  ra [9] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
                            5'h08, 5'h0F, 5'h10};
    logic [15:0] rv [9] = '{16'h0000, 16'h0000, 16'hA001, 16'hB002,
                            16'hC003, 16'h5A3C, 16'hD004, 16'h8000,
                            16'hC35A};
    for (int a = 9; a < 32; a++) begin
      if (a != 15 && a != 16) begin
        wr(5'(a), 16'hFFFF);
        rd(phy, 5'(a));
        chk(got, 16'h0000);
      end
    end
    wr(5'h07, 16'h5A3C);
    wr(5'h10, 16'hC35A);
    wr(5'h04, 16'hFFFF);
    for (int k = 0; k < 9; k++) begin
      rd(phy, ra[k]);
      chk(got, rv[k]);
    end
    chk(np_tx, 16'h5A3C);
    chk(irq_ctl, 16'hC35A);
    rd(phy + 5'h01, 5'h00);
    chk(got, 16'hFFFF);
  endtask

  task automatic t_status;
    st = '{1'b1, 1'b0, 1'b0};
    rd(phy, 5'h01);
    chk(got, 16'h01C8);
    st = '{1'b1, 1'b1, 1'b0};
    rd(phy, 5'h01);
    chk(got, 16'h01EC);
    st = '{1'b0, 1'b1, 1'b1};
    repeat (4) @(posedge mclk);
    #1 st = '{1'b1, 1'b1, 1'b0};
    rd(phy, 5'h01);
    chk(got, 16'h01F8);
    rd(phy, 5'h01);
    chk(got, 16'h01EC);
  endtask

  // ======
  // Sequence and watchdog
  initial begin
    repeat (20) @(posedge mclk);
    #1 rst_b = 1'b1;
    t_reset;
    t_fields;
    t_restart;
    t_pdown;
    t_map;
    t_status;
    finish_test;
  end

  // A full run takes about 10300 cycles; a little over three times that means a hang.
  initial begin
    repeat (33000) @(posedge mclk);
    err_total++;
    finish_test;
  end
endmodule
